/* File: servo_incremental_and_jog_mode_test.sv */
`timescale 1ns/1ps
module servo_incremental_and_jog_mode_test;
	import sijm_pkg::*;
	logic        clk, nrst, servo_on_request, auto_manual_select, register_motion_source_select;
	logic        abs_incr_select, forward_start, reverse_start, word_write;
	logic        motion_running, drive_ready_flag, fault, seen;
	logic [4:0]  point_table_number_select, selected_table;
	logic [3:0]  word_offset, command_system_digit;
	logic [15:0] word_data, rotation_direction_param, jog_speed_param, accel, decel, spd;
	logic [31:0] pos;
	sijm_motion_t motion_cmd;
	int          err_count, checks_done, n;

	sijm_host_model host (.clk(clk), .word_write(word_write), .word_offset(word_offset),
		.word_data(word_data));
	sijm_core #(.READY_DELAY(20), .FILTER_COUNT(2)) uut (.clk(clk), .nrst(nrst),
		.servo_on_request(servo_on_request), .fault(fault),
		.auto_manual_select(auto_manual_select),
		.register_motion_source_select(register_motion_source_select),
		.abs_incr_select(abs_incr_select), .forward_start(forward_start),
		.reverse_start(reverse_start), .point_table_number_select(point_table_number_select),
		.word_write(word_write), .word_offset(word_offset), .word_data(word_data),
		.command_system_digit(command_system_digit),
		.rotation_direction_param(rotation_direction_param),
		.jog_speed_param(jog_speed_param), .table1_accel_ms(accel), .table1_decel_ms(decel),
		.motion_cmd(motion_cmd), .motion_running(motion_running),
		.selected_table(selected_table), .drive_ready_flag(drive_ready_flag));

	always #50 clk = ~clk;

	task automatic print_verdict;
		if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	function automatic logic exp_cw(input logic fwd);
		return fwd == (rotation_direction_param == DIR_SWAP_VALUE);
	endfunction : exp_cw

	// Bounded wait on a one-cycle pulse, sampled after the edge settles
	task automatic wait_valid;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (motion_cmd.valid !== 1'b1 && n < 60);
		if (n >= 60) begin
			err_count++;
			print_verdict();
		end
	endtask : wait_valid

	task automatic settle;
		repeat (12) @(posedge clk);
	endtask : settle

	task automatic auto_move(input int i);
		pos = (i == 0) ? POS_LIMIT : (i == 1) ? 32'h0 : 32'($urandom_range(999999, 0));
		spd = 16'($urandom);
		host.write_words(pos, spd);
		@(posedge clk);
		abs_incr_select <= 1'($urandom);
		rotation_direction_param <= i[0] ? 16'h0001 : 16'h0000;
		settle();
		forward_start <= 1'b1;
		wait_valid();
		cmp("distance", pos, motion_cmd.distance);
		cmp("speed", 32'(spd), 32'(motion_cmd.speed));
		cmp("incremental", 32'h1, 32'(motion_cmd.incremental));
		cmp("auto cw", 32'(exp_cw(1'b1)), 32'(motion_cmd.cw));
		@(posedge clk);
		forward_start <= 1'b0;
		settle();
	endtask : auto_move

	task automatic jog(input logic fwd);
		@(posedge clk);
		point_table_number_select <= 5'($urandom);
		forward_start <= fwd;
		reverse_start <= !fwd;
		wait_valid();
		cmp("jog speed", 32'(jog_speed_param), 32'(motion_cmd.speed));
		cmp("jog accel", 32'(accel), 32'(motion_cmd.accel_ms));
		cmp("jog decel", 32'(decel), 32'(motion_cmd.decel_ms));
		cmp("jog cw", 32'(exp_cw(fwd)), 32'(motion_cmd.cw));
		cmp("table", 32'h0, 32'(selected_table));
		cmp("running", 32'h1, 32'(motion_running));
		@(posedge clk);
		forward_start <= 1'b0;
		reverse_start <= 1'b0;
		n = 0;
		while (motion_running !== 1'b0 && n < 60) begin
			@(posedge clk);
			n++;
		end
		cmp("stopped", 32'h0, 32'(motion_running));
		cmp("stop speed", 32'h0, 32'(motion_cmd.speed));
	endtask : jog

	initial begin
		void'($urandom(2477));
		{clk, nrst, servo_on_request, auto_manual_select, abs_incr_select} = '0;
		{forward_start, reverse_start, register_motion_source_select, fault, seen} = '0;
		point_table_number_select = 5'h00;
		command_system_digit = 4'h0;
		rotation_direction_param = 16'h0000;
		jog_speed_param = 16'($urandom);
		accel = 16'($urandom);
		decel = 16'h0003;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		servo_on_request <= 1'b1;
		for (n = 0; n < 60 && drive_ready_flag !== 1'b1; n++) @(posedge clk);
		cmp("ready", 32'h1, 32'(drive_ready_flag));
		command_system_digit <= CMD_DIGIT_INCR;
		auto_manual_select <= 1'b1;
		register_motion_source_select <= 1'b1;
		settle();
		for (int i = 0; i < 6; i++) auto_move(i);
		command_system_digit <= 4'h0;
		settle();
		forward_start <= 1'b1;
		seen = 1'b0;
		repeat (20) begin
			@(posedge clk);
			#1;
			if (motion_cmd.valid !== 1'b0) seen = 1'b1;
		end
		cmp("refused start", 32'h0, 32'(seen));
		@(posedge clk);
		forward_start <= 1'b0;
		settle();
		auto_manual_select <= 1'b0;
		settle();
		for (int i = 0; i < 4; i++) begin
			rotation_direction_param <= i[1] ? 16'h0001 : 16'h0000;
			settle();
			jog(i[0]);
		end
		@(posedge clk);
		fault <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		cmp("ready fault", 32'h0, 32'(drive_ready_flag));
		@(posedge clk);
		fault <= 1'b0;
		for (n = 0; n < 60 && drive_ready_flag !== 1'b1; n++) @(posedge clk);
		cmp("ready again", 32'h1, 32'(drive_ready_flag));
		print_verdict();
	end
endmodule : servo_incremental_and_jog_mode_test

/* File: sijm_core.sv */
`timescale 1ns/1ps
module sijm_core
	import sijm_pkg::*;
#(
	parameter int READY_DELAY  = READY_CYCLES,
	parameter int FILTER_COUNT = FILTER_DEFAULT
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Remote input bits
	input  wire logic         servo_on_request,
	input  wire logic         fault,
	input  wire logic         auto_manual_select,
	input  wire logic         register_motion_source_select,
	input  wire logic         abs_incr_select,
	input  wire logic         forward_start,
	input  wire logic         reverse_start,
	input  wire logic [4:0]   point_table_number_select,
	// Remote word registers
	input  wire logic         word_write,
	input  wire logic [3:0]   word_offset,
	input  wire logic [15:0]  word_data,
	// Configuration parameters
	input  wire logic [3:0]   command_system_digit,
	input  wire logic [15:0]  rotation_direction_param,
	input  wire logic [15:0]  jog_speed_param,
	input  wire logic [15:0]  table1_accel_ms,
	input  wire logic [15:0]  table1_decel_ms,
	// Motion command and status
	output sijm_motion_t      motion_cmd,
	output logic              motion_running,
	output logic [4:0]        selected_table,
	output logic              drive_ready_flag
);
	logic        rst_a;
	logic        rst_b;
	logic [9:0]  s1;
	logic [9:0]  s2;
	logic [9:0]  filt;
	logic [9:0]  filt_prev;
	logic [15:0] fcnt [10];
	logic [15:0] pos_low;
	logic [15:0] pos_high;
	logic [15:0] speed_word;
	logic [31:0] rcnt;
	logic        fwd_prev;
	logic        rev_prev;
	sijm_state_t state;
	wire         rst_n = rst_b;
	wire  [9:0]  raw = {point_table_number_select, servo_on_request, auto_manual_select,
		register_motion_source_select, forward_start, reverse_start};
	wire         f_rev    = filt[0];
	wire         f_fwd    = filt[1];
	wire         f_regsrc = filt[2];
	wire         f_auto   = filt[3];
	wire         f_son    = filt[4];
	wire         incr_sys = (command_system_digit == CMD_DIGIT_INCR);
	wire         swap     = (rotation_direction_param == DIR_SWAP_VALUE);

	function automatic logic dir_cw(input logic fwd, input logic sw);
		dir_cw = sw ? fwd : ~fwd;
	endfunction : dir_cw

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_a <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_b <= rst_a;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 10'h000;
			s2 <= 10'h000;
		end else begin
			s1 <= raw;
			s2 <= s1;
		end
	end

	// Each bit must hold steady for the filter time before it is believed
	for (genvar i = 0; i < 10; i++) begin : g_filt
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				fcnt[i] <= 16'h0000;
				filt[i] <= 1'b0;
			end else if (s2[i] == filt[i]) begin
				fcnt[i] <= 16'h0000;
			end else if (fcnt[i] >= 16'(FILTER_COUNT - 1)) begin
				fcnt[i] <= 16'h0000;
				filt[i] <= s2[i];
			end else begin
				fcnt[i] <= fcnt[i] + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_prev <= 10'h000;
		end else begin
			filt_prev <= filt;
		end
	end

	// Words are latched as written; the command takes them at the forward-start edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_low    <= 16'h0000;
			pos_high   <= 16'h0000;
			speed_word <= 16'h0000;
		end else if (word_write) begin
			case (word_offset)
				OFS_POS_LOW:  pos_low <= word_data;
				OFS_POS_HIGH: pos_high <= word_data;
				OFS_SPEED:    speed_word <= word_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rcnt             <= 32'h00000000;
			drive_ready_flag <= 1'b0;
		end else if (!f_son || fault) begin
			rcnt             <= 32'h00000000;
			drive_ready_flag <= 1'b0;
		end else if (rcnt >= 32'(READY_DELAY - 1)) begin
			drive_ready_flag <= 1'b1;
		end else begin
			rcnt <= rcnt + 32'h00000001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			selected_table <= 5'h00;
		end else begin
			// Manual mode never looks at the table selects
			selected_table <= f_auto ? filt[9:5] : 5'h00;
		end
	end

	wire fwd_rise = f_fwd & ~filt_prev[1];
	wire rev_rise = f_rev & ~filt_prev[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state          <= SIJM_IDLE;
			motion_cmd     <= '0;
			motion_running <= 1'b0;
			fwd_prev       <= 1'b0;
			rev_prev       <= 1'b0;
		end else begin
			motion_cmd.valid <= 1'b0;
			fwd_prev         <= f_fwd;
			rev_prev         <= f_rev;
			case (state)
				SIJM_IDLE: begin
					motion_running <= 1'b0;
					if (drive_ready_flag && f_auto && f_regsrc && incr_sys && fwd_rise) begin
						// Relative move; abs/incr select is not consulted
						motion_cmd.valid       <= 1'b1;
						motion_cmd.distance    <= {pos_high, pos_low};
						motion_cmd.speed       <= speed_word;
						motion_cmd.accel_ms    <= table1_accel_ms;
						motion_cmd.decel_ms    <= table1_decel_ms;
						motion_cmd.cw          <= dir_cw(1'b1, swap);
						motion_cmd.incremental <= 1'b1;
						motion_running         <= 1'b1;
						state                  <= SIJM_AUTO;
					end else if (drive_ready_flag && !f_auto && (fwd_rise ^ rev_rise)) begin
						motion_cmd.valid       <= 1'b1;
						motion_cmd.distance    <= 32'h00000000;
						motion_cmd.speed       <= jog_speed_param;
						motion_cmd.accel_ms    <= table1_accel_ms;
						motion_cmd.decel_ms    <= table1_decel_ms;
						motion_cmd.cw          <= dir_cw(fwd_rise, swap);
						motion_cmd.incremental <= 1'b0;
						motion_running         <= 1'b1;
						state                  <= SIJM_JOG;
					end
				end
				SIJM_AUTO: begin
					// One-shot relative move; completion is the motion unit's business
					state <= SIJM_STOP;
				end
				SIJM_JOG: begin
					if (!drive_ready_flag || f_auto || !(f_fwd || f_rev)) begin
						motion_cmd.speed <= 16'h0000;
						state            <= SIJM_STOP;
					end
				end
				SIJM_STOP: begin
					motion_running <= 1'b0;
					motion_cmd.speed <= 16'h0000;
					state          <= SIJM_IDLE;
				end
				default: state <= SIJM_IDLE;
			endcase
		end
	end

	chk_ready_low_fault: assert property (@(posedge clk) disable iff (!rst_n)
		(fault ##1 1) |=> !drive_ready_flag) else $error("ready while faulted");
	chk_manual_table_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(!f_auto ##1 !f_auto) |-> selected_table == 5'h00) else $error("table in manual");
	chk_jog_speed: assert property (@(posedge clk) disable iff (!rst_n)
		(motion_cmd.valid && !motion_cmd.incremental) |-> motion_cmd.speed == $past(jog_speed_param))
		else $error("jog speed wrong");
	chk_jog_times: assert property (@(posedge clk) disable iff (!rst_n)
		(motion_cmd.valid && !motion_cmd.incremental) |-> motion_cmd.accel_ms == $past(table1_accel_ms))
		else $error("jog accel wrong");
	chk_jog_release: assert property (@(posedge clk) disable iff (!rst_n)
		(state == SIJM_JOG && !f_fwd && !f_rev) |=> state == SIJM_STOP) else $error("jog kept");
	chk_auto_incr: assert property (@(posedge clk) disable iff (!rst_n)
		motion_cmd.valid && motion_cmd.incremental |-> $past(incr_sys) && $past(f_regsrc))
		else $error("auto without incr");
	chk_pos_pair: assert property (@(posedge clk) disable iff (!rst_n)
		motion_cmd.valid && motion_cmd.incremental |-> motion_cmd.distance == $past({pos_high, pos_low}))
		else $error("position pair wrong");
	chk_jog_dir: assert property (@(posedge clk) disable iff (!rst_n)
		(motion_cmd.valid && !motion_cmd.incremental) |-> motion_cmd.cw == ($past(swap) ~^ $past(fwd_rise)))
		else $error("jog direction wrong");

	// Independent count of settled servo-on cycles without fault.
	// Kept apart from the ready counter so that the timing checks below
	// do not simply restate the logic that they guard.
	logic [31:0] ready_age;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_age <= 32'h00000000;
		end else if (!f_son || fault) begin
			ready_age <= 32'h00000000;
		end else if (ready_age != 32'hFFFFFFFF) begin
			// Saturates so a long servo-on never wraps back below the delay
			ready_age <= ready_age + 32'h00000001;
		end
	end

	// Ready timing against the independent count
	chk_ready_early: assert property (@(posedge clk) disable iff (!rst_n)
		drive_ready_flag |-> ready_age >= 32'(READY_DELAY))
		else $error("ready raised too early");

	chk_ready_late: assert property (@(posedge clk) disable iff (!rst_n)
		(ready_age >= 32'(READY_DELAY)) |-> drive_ready_flag)
		else $error("ready raised too late");

	// Command issue conditions and command contents
	chk_start_ready: assert property (@(posedge clk) disable iff (!rst_n)
		motion_cmd.valid |-> $past(drive_ready_flag))
		else $error("command while not ready");

	chk_jog_manual: assert property (@(posedge clk) disable iff (!rst_n)
		(motion_cmd.valid && !motion_cmd.incremental) |-> !$past(f_auto))
		else $error("jog outside manual mode");

	chk_auto_mode: assert property (@(posedge clk) disable iff (!rst_n)
		(motion_cmd.valid && motion_cmd.incremental) |-> $past(f_auto))
		else $error("relative move outside auto mode");

	chk_jog_decel: assert property (@(posedge clk) disable iff (!rst_n)
		(motion_cmd.valid && !motion_cmd.incremental) |-> motion_cmd.decel_ms == $past(table1_decel_ms))
		else $error("jog decel wrong");

	chk_auto_speed: assert property (@(posedge clk) disable iff (!rst_n)
		(motion_cmd.valid && motion_cmd.incremental) |-> motion_cmd.speed == $past(speed_word))
		else $error("auto speed wrong");

	chk_jog_one_start: assert property (@(posedge clk) disable iff (!rst_n)
		(motion_cmd.valid && !motion_cmd.incremental) |-> $past(fwd_rise) != $past(rev_rise))
		else $error("jog from two starts");

	// Jog life cycle
	chk_jog_running: assert property (@(posedge clk) disable iff (!rst_n)
		state == SIJM_JOG |-> motion_running)
		else $error("jog without running flag");

	chk_stop_speed: assert property (@(posedge clk) disable iff (!rst_n)
		($past(state) == SIJM_JOG && state == SIJM_STOP) |-> motion_cmd.speed == 16'h0000)
		else $error("jog stop kept speed");

	// A filtered edge needs the synchronised level behind it
	chk_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(f_fwd) |-> $past(s2[1]))
		else $error("start believed before filter");
endmodule : sijm_core

/* File: sijm_host_model.sv */
`timescale 1ns/1ps
module sijm_host_model
	import sijm_pkg::*;
(
	// Clock
	input  wire logic  clk,
	// Word writes
	output logic        word_write,
	output logic [3:0]  word_offset,
	output logic [15:0] word_data
);
	initial begin
		word_write = 1'b0;
		word_offset = 4'h0;
		word_data = 16'h0000;
	end

	task automatic write_words(input logic [31:0] pos, input logic [15:0] spd);
		if (pos > POS_LIMIT) pos = POS_LIMIT;
		@(posedge clk);
		word_write <= 1'b1;
		word_offset <= OFS_POS_LOW;
		word_data <= pos[15:0];
		@(posedge clk);
		word_offset <= OFS_POS_HIGH;
		word_data <= pos[31:16];
		@(posedge clk);
		word_offset <= OFS_SPEED;
		word_data <= spd;
		@(posedge clk);
		word_write <= 1'b0;
		// Released bus shows junk, never a stale word
		word_data <= ~spd;
	endtask : write_words
endmodule : sijm_host_model

/* File: sijm_pkg.sv */
package sijm_pkg;
	localparam logic [3:0]  OFS_POS_LOW    = 4'h4;
	localparam logic [3:0]  OFS_POS_HIGH   = 4'h5;
	localparam logic [3:0]  OFS_SPEED      = 4'h6;
	localparam logic [3:0]  CMD_DIGIT_INCR = 4'h1;
	localparam logic [15:0] DIR_SWAP_VALUE = 16'h0001;
	localparam logic [31:0] POS_LIMIT      = 32'h000F423F;
	localparam int          CLK_HZ         = 10000000;
	localparam int          READY_MS       = 80;
	localparam int          READY_CYCLES   = READY_MS * (CLK_HZ / 1000);
	localparam int          FILTER_DEFAULT = 16;

	typedef struct packed {
		logic        valid;
		logic [31:0] distance;
		logic [15:0] speed;
		logic [15:0] accel_ms;
		logic [15:0] decel_ms;
		logic        cw;
		logic        incremental;
	} sijm_motion_t;

	typedef enum logic [1:0] {
		SIJM_IDLE = 2'b00,
		SIJM_AUTO = 2'b01,
		SIJM_JOG  = 2'b11,
		SIJM_STOP = 2'b10
	} sijm_state_t;
endpackage : sijm_pkg
